// [bsr_params.svh]
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH

// Register byte offsets
`define BSR_OFS_MODE       8'h00
`define BSR_OFS_ON_VOLT    8'h04
`define BSR_OFS_OFF_VOLT   8'h08
`define BSR_OFS_INT_RES    8'h0c
`define BSR_OFS_INT_PWR    8'h10
`define BSR_OFS_INT_INIT   8'h14
`define BSR_OFS_INT_CONT   8'h18
`define BSR_OFS_EXT_RES    8'h1c
`define BSR_OFS_EXT_PWR    8'h20
`define BSR_OFS_EXT_INIT   8'h24
`define BSR_OFS_EXT_CONT   8'h28
`define BSR_OFS_MAX_CUR    8'h2c
`define BSR_OFS_CTRL       8'h30
`define BSR_OFS_STATUS     8'h34
`define BSR_OFS_PWR_FILT   8'h38
`define BSR_OFS_PWR_CAP    8'h3c

// Control register fields
`define BSR_CTRL_SAVE      0
`define BSR_CTRL_FCLR      1

// Mode selector codes
`define BSR_MODE_OFF       3'h0
`define BSR_MODE_DUTY      3'h1
`define BSR_MODE_DUTY_PF   3'h2
`define BSR_MODE_PF        3'h3
`define BSR_MODE_WARN      3'h4

// Reset values
`define BSR_RST_MODE       3'h1
`define BSR_RST_ON_VOLT    16'h030c
`define BSR_RST_OFF_VOLT   16'h02f8
`define BSR_RST_INIT_MS    16'h0014
`define BSR_RST_CONT_MS    16'h0002

// Display codes, values arbitrary
`define BSR_CODE_NONE      8'h00
`define BSR_CODE_WARN      8'h01
`define BSR_CODE_CFG       8'h02
`define BSR_CODE_PFAULT    8'h03

// Timing: control tick of 1000 us at a 10 ns clock
`define BSR_TICK_US        1000
`define BSR_CLK_NS         10
`define BSR_FILT_SHIFT     4
`define BSR_WARN_NUM       20'h00009
`define BSR_WARN_DEN       20'h0000a

`endif

// [bsr_pkg.sv]
package bsr_pkg;

  typedef enum logic [1:0] {
    BSR_IDLE,
    BSR_ON,
    BSR_FORCE,
    BSR_FREE
  } bsr_state_e;

  // Measurements and internal resistor data from the power stage
  typedef struct packed {
    logic [15:0] bus_volt;
    logic [15:0] brake_power;
    logic        has_int_res;
    logic [15:0] int_res;
    logic [15:0] int_pwr;
    logic [15:0] int_init_ms;
    logic [15:0] int_cont_ms;
    logic [15:0] max_cur;
  } bsr_stage_s;

  // Drive to the power stage and indications
  typedef struct packed {
    logic       brake_on;
    logic       drive_disable;
    logic       power_fault;
    logic       config_fault;
    logic       power_warn;
    logic [7:0] display_code;
  } bsr_status_s;

  // Whole state of the controller
  typedef struct packed {
    logic [2:0]  mode;
    logic [15:0] von;
    logic [15:0] voff;
    logic [15:0] ir;
    logic [15:0] ip;
    logic [15:0] ii;
    logic [15:0] ic;
    logic [15:0] er;
    logic [15:0] ep;
    logic [15:0] ei;
    logic [15:0] ec;
    logic [15:0] imax;
    logic        ext_saved;
    logic        init_done;
    logic [7:0]  haddr;
    logic        hwr;
    logic        hact;
    logic [31:0] rdata;
    logic [31:0] tick_cnt;
    logic        req;
    bsr_state_e  state;
    logic [15:0] on_left;
    logic [15:0] off_left;
    logic [15:0] rest;
    logic [31:0] filt;
    logic        pfault;
    logic        warn;
    logic        recalc;
    logic        div_busy;
    logic [5:0]  div_cnt;
    logic [31:0] div_rem;
    logic [31:0] div_quo;
    logic [31:0] div_den;
    logic [15:0] k;
    bsr_status_s st;
  } bsr_regs_s;

endpackage : bsr_pkg

// [bsr_shunt_ctrl.sv]
// Overview of operation
// - Brake on above turn-on threshold
// - Brake off below turn-off threshold
// - Mode 0 off, 1-4 as listed
// - Mode 0 never turns brake on
// - Initial on-time budget used first
// - Later off time from continuous on-time
// - Long rest restores initial budget
// - Modes 2,3 fault on average overpower
// - Mode 3 thresholds only, fault protects
// - Mode 4 thresholds only, warning only
// - Warning above 90% of capability
// - Duty protects lower-rated resistor
// - Duty computed from lower-rated resistor data
// - Internal resistor data loaded automatically
// - External-only needs saved nonzero data
// - Too low resistance is configuration fault
// - Separate on-times per resistor
// - Filtered power and capability readable
`timescale 1ns/1ps
`include "bsr_params.svh"

module bsr_shunt_ctrl
  import bsr_pkg::*;
#(
  parameter int TICK_CYC = `BSR_TICK_US * 1000 / `BSR_CLK_NS
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire bsr_stage_s  stage_i,
  output bsr_status_s      status_o
);

  bsr_regs_s   q;
  bsr_regs_s   d;
  logic        tick;
  logic        duty;
  logic        allow;
  logic        int_ok;
  logic        ext_ok;
  logic        pick_int;
  logic        cfg_fault;
  logic [15:0] lim_r;
  logic [15:0] lim_p;
  logic [15:0] lim_init;
  logic [15:0] lim_cont;
  logic [15:0] kd;
  logic [15:0] init_off;
  logic [15:0] cont_off;
  logic [16:0] cap;
  logic [15:0] pwr_filt;
  logic [32:0] div_tmp;

  // A resistor counts only with both values nonzero
  function automatic logic present(input logic [15:0] r, input logic [15:0] p);
    present = (r != 16'h0000) && (p != 16'h0000);
  endfunction : present

  // Turn-on current von/r above the transistor rating
  function automatic logic over_cur(input logic [15:0] v, input logic [15:0] r,
                                    input logic [15:0] imax);
    over_cur = {16'h0000, v} > (32'(r) * 32'(imax));
  endfunction : over_cur

  // Off time scaled from an on time, saturating
  function automatic logic [15:0] sat_mul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = 32'(a) * 32'(b);
    sat_mul = (p[31:16] != 16'h0000) ? 16'hffff : p[15:0];
  endfunction : sat_mul

  // Read decode of the register map
  function automatic logic [31:0] rd_word(input bsr_regs_s s, input logic [7:0] a,
                                          input logic [16:0] c, input logic [15:0] f);
    case (a)
      `BSR_OFS_MODE:     rd_word = {29'h0, s.mode};
      `BSR_OFS_ON_VOLT:  rd_word = {16'h0, s.von};
      `BSR_OFS_OFF_VOLT: rd_word = {16'h0, s.voff};
      `BSR_OFS_INT_RES:  rd_word = {16'h0, s.ir};
      `BSR_OFS_INT_PWR:  rd_word = {16'h0, s.ip};
      `BSR_OFS_INT_INIT: rd_word = {16'h0, s.ii};
      `BSR_OFS_INT_CONT: rd_word = {16'h0, s.ic};
      `BSR_OFS_EXT_RES:  rd_word = {16'h0, s.er};
      `BSR_OFS_EXT_PWR:  rd_word = {16'h0, s.ep};
      `BSR_OFS_EXT_INIT: rd_word = {16'h0, s.ei};
      `BSR_OFS_EXT_CONT: rd_word = {16'h0, s.ec};
      `BSR_OFS_MAX_CUR:  rd_word = {16'h0, s.imax};
      `BSR_OFS_CTRL:     rd_word = {31'h0, s.ext_saved};
      `BSR_OFS_STATUS:   rd_word = {16'h0, s.st.display_code, 2'h0, s.req, s.st.config_fault,
                                    s.st.power_fault, s.st.power_warn, s.st.drive_disable,
                                    s.st.brake_on};
      `BSR_OFS_PWR_FILT: rd_word = {16'h0, f};
      `BSR_OFS_PWR_CAP:  rd_word = {15'h0, c};
      default:           rd_word = 32'h0;
    endcase
  endfunction : rd_word

  assign tick = (q.tick_cnt == 32'(TICK_CYC - 1));

  assign duty  = (q.mode == `BSR_MODE_DUTY) || (q.mode == `BSR_MODE_DUTY_PF);
  assign allow = (q.mode != `BSR_MODE_OFF) && !cfg_fault && !q.pfault;

  // the lower-rated resistor sets the limits
  assign int_ok   = stage_i.has_int_res && present(q.ir, q.ip);
  assign ext_ok   = present(q.er, q.ep);
  assign pick_int = int_ok && (!ext_ok || (q.ip <= q.ep));
  assign lim_r    = pick_int ? q.ir : q.er;
  assign lim_p    = pick_int ? q.ip : q.ep;
  assign lim_init = pick_int ? q.ii : q.ei;
  assign lim_cont = pick_int ? q.ic : q.ec;

  // external-only unit needs saved nonzero data
  // resistance too low for the transistor
  assign cfg_fault = (!int_ok && !(ext_ok && q.ext_saved))
                   || (int_ok && over_cur(q.von, q.ir, q.imax))
                   || (ext_ok && over_cur(q.von, q.er, q.imax));

  // off time is on time times (k - 1)
  assign kd       = (q.k == 16'h0000) ? 16'h0000 : q.k - 16'h0001;
  assign init_off = sat_mul(lim_init, kd);
  assign cont_off = sat_mul(lim_cont, kd);

  // capability is the sum of fitted ratings
  assign cap      = (int_ok ? 17'(q.ip) : 17'h0) + (ext_ok ? 17'(q.ep) : 17'h0);
  assign pwr_filt = q.filt[31:16];
  assign div_tmp  = {q.div_rem, q.div_quo[31]};

  // Next-state logic for the whole controller
  always_comb begin
    d          = q;
    d.recalc   = 1'b0;
    d.tick_cnt = tick ? 32'h0 : q.tick_cnt + 32'h1;

    // AHB address phase; read data ready for the data phase
    d.hact = hsel_i && htrans_i[1] && hready_i;
    if (d.hact) begin
      d.haddr = haddr_i[7:0];
      d.hwr   = hwrite_i;
      if (!hwrite_i) begin
        d.rdata = rd_word(q, haddr_i[7:0], cap, pwr_filt);
      end
    end

    // AHB data phase write; unmapped and read-only words ignore it
    if (q.hact && q.hwr) begin
      d.recalc = 1'b1;
      case (q.haddr)
        `BSR_OFS_MODE: begin
          // codes above 4 are not accepted
          if (hwdata_i[31:3] == 29'h0 && hwdata_i[2:0] <= `BSR_MODE_WARN) begin
            d.mode = hwdata_i[2:0];
          end
        end
        `BSR_OFS_ON_VOLT:  d.von  = hwdata_i[15:0];
        `BSR_OFS_OFF_VOLT: d.voff = hwdata_i[15:0];
        `BSR_OFS_INT_RES:  d.ir   = hwdata_i[15:0];
        `BSR_OFS_INT_PWR:  d.ip   = hwdata_i[15:0];
        `BSR_OFS_INT_INIT: d.ii   = hwdata_i[15:0];
        `BSR_OFS_INT_CONT: d.ic   = hwdata_i[15:0];
        `BSR_OFS_EXT_RES: begin
          d.er        = hwdata_i[15:0];
          d.ext_saved = 1'b0;
        end
        `BSR_OFS_EXT_PWR: begin
          d.ep        = hwdata_i[15:0];
          d.ext_saved = 1'b0;
        end
        `BSR_OFS_EXT_INIT: d.ei   = hwdata_i[15:0];
        `BSR_OFS_EXT_CONT: d.ec   = hwdata_i[15:0];
        `BSR_OFS_MAX_CUR:  d.imax = hwdata_i[15:0];
        `BSR_OFS_CTRL: begin
          if (hwdata_i[`BSR_CTRL_SAVE]) begin
            d.ext_saved = 1'b1;
          end
          if (hwdata_i[`BSR_CTRL_FCLR]) begin
            d.pfault = 1'b0;
          end
        end
        default: d.recalc = 1'b0;
      endcase
    end

    // internal resistor data taken once after reset
    if (!q.init_done) begin
      d.init_done = 1'b1;
      d.recalc    = 1'b1;
      d.imax      = stage_i.max_cur;
      if (stage_i.has_int_res) begin
        d.ir = stage_i.int_res;
        d.ip = stage_i.int_pwr;
        d.ii = stage_i.int_init_ms;
        d.ic = stage_i.int_cont_ms;
      end
    end

    // k = von^2 / (r * p), restarted on any change
    if (q.recalc) begin
      d.div_busy = 1'b1;
      d.div_cnt  = 6'h20;
      d.div_rem  = 32'h0;
      d.div_quo  = 32'(q.von) * 32'(q.von);
      d.div_den  = 32'(lim_r) * 32'(lim_p);
    end else if (q.div_busy) begin
      if (div_tmp >= {1'b0, q.div_den}) begin
        d.div_rem = 32'(div_tmp - {1'b0, q.div_den});
        d.div_quo = {q.div_quo[30:0], 1'b1};
      end else begin
        d.div_rem = div_tmp[31:0];
        d.div_quo = {q.div_quo[30:0], 1'b0};
      end
      d.div_cnt = q.div_cnt - 6'h01;
      if (q.div_cnt == 6'h01) begin
        d.div_busy = 1'b0;
        d.k        = (d.div_quo[31:16] != 16'h0) ? 16'hffff : d.div_quo[15:0];
      end
    end

    if (tick) begin
      if (stage_i.bus_volt > q.von) begin
        d.req = 1'b1;
      end else if (stage_i.bus_volt < q.voff) begin
        d.req = 1'b0;
      end
      if ({stage_i.brake_power, 16'h0} < q.filt) begin
        d.filt = q.filt - ((q.filt - {stage_i.brake_power, 16'h0}) >> `BSR_FILT_SHIFT);
      end else begin
        d.filt = q.filt + (({stage_i.brake_power, 16'h0} - q.filt) >> `BSR_FILT_SHIFT);
      end
      // warning above 90 percent of capability
      // Products kept at 24 bits so nine times the capability cannot wrap
      d.warn = (24'(pwr_filt) * 24'(`BSR_WARN_DEN)) > (24'(cap) * 24'(`BSR_WARN_NUM));
      // power fault in modes 2 and 3; set wins over clear
      if ((q.mode == `BSR_MODE_DUTY_PF || q.mode == `BSR_MODE_PF)
          && (17'(pwr_filt) > cap)) begin
        d.pfault = 1'b1;
      end
    end

    // Brake state machine
    case (q.state)
      BSR_IDLE: begin
        if (tick && q.rest != 16'hffff) begin
          d.rest = q.rest + 16'h0001;
        end
        // nothing switches on while disallowed or off
        if (allow && q.req) begin
          if (duty) begin
            d.state = BSR_ON;
            // long rest restores the initial budget
            if (q.rest >= init_off) begin
              d.on_left  = lim_init;
            end
          end else begin
            // mode 3 and mode 4 switch by thresholds only
            d.state = BSR_FREE;
          end
        end
      end
      BSR_ON: begin
        if (!allow || !duty || !q.req) begin
          d.state = BSR_IDLE;
          d.rest  = 16'h0000;
        end else if (tick) begin
          if (q.on_left <= 16'h0001) begin
            // forced off always from continuous on-time
            d.state    = BSR_FORCE;
            d.off_left = cont_off;
            d.on_left  = 16'h0000;
          end else begin
            d.on_left = q.on_left - 16'h0001;
          end
        end
      end
      BSR_FORCE: begin
        if (!allow) begin
          d.state   = BSR_IDLE;
          d.rest    = 16'h0000;
          d.on_left = lim_cont;
        end else if (tick) begin
          if (q.off_left <= 16'h0001) begin
            // continuous on-time after the forced off
            d.state   = BSR_IDLE;
            d.rest    = 16'h0000;
            d.on_left = lim_cont;
          end else begin
            d.off_left = q.off_left - 16'h0001;
          end
        end
      end
      BSR_FREE: begin
        if (!allow || duty || !q.req) begin
          d.state = BSR_IDLE;
        end
      end
      default: d.state = BSR_IDLE;
    endcase

    // Registered outputs
    d.st.brake_on      = (d.state == BSR_ON) || (d.state == BSR_FREE);
    d.st.power_fault   = d.pfault;
    d.st.config_fault  = cfg_fault;
    d.st.drive_disable = d.pfault || cfg_fault;
    d.st.power_warn    = d.warn;
    if (d.pfault) begin
      d.st.display_code = `BSR_CODE_PFAULT;
    end else if (cfg_fault) begin
      d.st.display_code = `BSR_CODE_CFG;
    end else if (d.warn) begin
      d.st.display_code = `BSR_CODE_WARN;
    end else begin
      d.st.display_code = `BSR_CODE_NONE;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.mode     <= `BSR_RST_MODE;
      q.von      <= `BSR_RST_ON_VOLT;
      q.voff     <= `BSR_RST_OFF_VOLT;
      q.ii       <= `BSR_RST_INIT_MS;
      q.ic       <= `BSR_RST_CONT_MS;
      q.ei       <= `BSR_RST_INIT_MS;
      q.ec       <= `BSR_RST_CONT_MS;
      q.rest     <= 16'hffff;
      q.state    <= BSR_IDLE;
    end else begin
      q <= d;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = q.rdata;
  assign status_o    = q.st;

endmodule : bsr_shunt_ctrl

// [bsr_monitor.sv]
`timescale 1ns/1ps
`include "bsr_params.svh"

module bsr_monitor
  import bsr_pkg::*;
#(
  parameter int TICK_CYC = 100000
) (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire bsr_stage_s  stage_i,
  input wire bsr_status_s status_o
);
  logic        wr_q, rd_q, clr_q;
  logic [7:0]  a_q;
  logic [2:0]  mode_q;
  logic [15:0] von_q, voff_q;
  logic [31:0] hi_q, lo_q;
  bsr_status_s s;

  assign s = status_o;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Shadow of written settings; any write restarts the settle counts,
  // so a fresh setting always gets a full tick before it is judged
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      {wr_q, rd_q, clr_q, a_q, hi_q, lo_q} <= '0;
      mode_q <= `BSR_RST_MODE;
      von_q  <= `BSR_RST_ON_VOLT;
      voff_q <= `BSR_RST_OFF_VOLT;
    end else begin
      wr_q  <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
      rd_q  <= hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
      a_q   <= haddr_i[7:0];
      clr_q <= wr_q && a_q == `BSR_OFS_CTRL && hwdata_i[`BSR_CTRL_FCLR];
      if (wr_q && a_q == `BSR_OFS_MODE && hwdata_i <= 32'h4) mode_q <= hwdata_i[2:0];
      if (wr_q && a_q == `BSR_OFS_ON_VOLT) von_q <= hwdata_i[15:0];
      if (wr_q && a_q == `BSR_OFS_OFF_VOLT) voff_q <= hwdata_i[15:0];
      hi_q <= (wr_q || stage_i.bus_volt <= von_q) ? '0 : hi_q + 32'h1;
      lo_q <= (wr_q || stage_i.bus_volt >= voff_q) ? '0 : lo_q + 32'h1;
    end
  end

  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("slave stalled or answered an error");
  a_unmapped_zero: assert property (rd_q && a_q >= 8'h40 |-> hrdata_o == 32'h0)
    else $error("unmapped word read nonzero");
  a_off_no_brake: assert property (mode_q == 3'h0 && $past(mode_q) == 3'h0 &&
    $past(mode_q, 2) == 3'h0 |-> !s.brake_on) else $error("brake on while switched off");
  a_hyst_on: assert property (hi_q > TICK_CYC + 2 && mode_q >= 3'h3 && !s.config_fault &&
    !s.power_fault |-> s.brake_on or ##[0:1] s.power_fault)
    else $error("brake not on above turn-on level");
  a_hyst_off: assert property (lo_q > TICK_CYC + 2 |-> !s.brake_on)
    else $error("brake still on below turn-off level");
  a_fault_no_brake: assert property ((s.config_fault && $past(s.config_fault)) ||
    (s.power_fault && $past(s.power_fault)) |-> !s.brake_on)
    else $error("brake on during a fault");
  a_pf_disable: assert property (s.power_fault && $past(s.power_fault) |->
    s.drive_disable && s.display_code == `BSR_CODE_PFAULT)
    else $error("power fault without disable or code");
  a_pf_mode: assert property ($rose(s.power_fault) |-> $past(mode_q) inside {3'h2, 3'h3})
    else $error("power fault raised outside fault modes");
  a_pf_latch: assert property ($fell(s.power_fault) |-> clr_q || $past(clr_q) ||
    $past(clr_q, 2) || $past(clr_q, 3)) else $error("power fault dropped without clear");
  a_warn_code: assert property ((s.power_warn && !s.power_fault && !s.config_fault)[*2]
    |-> s.display_code == `BSR_CODE_WARN) else $error("warning without its code");
endmodule : bsr_monitor

bind bsr_shunt_ctrl bsr_monitor #(.TICK_CYC(TICK_CYC)) i_bsr_monitor (
  .mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .stage_i(stage_i),
  .status_o(status_o));

// [bsr_stage_model.sv]
`timescale 1ns/1ps

module bsr_stage_model
  import bsr_pkg::*;
#(
  parameter logic [15:0] INT_RES  = 16'h0064,
  parameter logic [15:0] INT_PWR  = 16'h03e8,
  parameter logic [15:0] INT_INIT = 16'h0005,
  parameter logic [15:0] INT_CONT = 16'h0001,
  parameter logic [15:0] MAX_CUR  = 16'h0014
) (
  input  wire logic        brake_on_i,
  input  wire logic        fitted_i,
  input  wire logic [15:0] volt_i,
  input  wire logic [15:0] load_pwr_i,
  output bsr_stage_s       stage_o
);
  // Power only flows while the transistor conducts
  always_comb begin
    stage_o.bus_volt    = volt_i;
    stage_o.brake_power = brake_on_i ? load_pwr_i : 16'h0;
    stage_o.has_int_res = fitted_i;
    stage_o.max_cur     = MAX_CUR;
    // resistor data supplied
    // Unfitted stage shows junk, so the controller must ignore it
    stage_o.int_res     = fitted_i ? INT_RES : ~INT_RES;
    stage_o.int_pwr     = fitted_i ? INT_PWR : ~INT_PWR;
    stage_o.int_init_ms = fitted_i ? INT_INIT : ~INT_INIT;
    stage_o.int_cont_ms = fitted_i ? INT_CONT : ~INT_CONT;
  end
endmodule : bsr_stage_model

// [tb_top.sv]
`timescale 1ns/1ps
`include "bsr_params.svh"

module tb_top
  import bsr_pkg::*;
;
  localparam int TICK = 20;
  localparam int BRK = 12, DIS = 11, PF = 10, CFG = 9, WRN = 8;
  localparam logic [7:0]  RA[14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                                     8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h3c, 8'h40};
  localparam logic [15:0] RV[14] = '{16'h0001, 16'h030c, 16'h02f8, 16'h0064, 16'h03e8,
                                     16'h0005, 16'h0001, 16'h0000, 16'h0000, 16'h0014,
                                     16'h0002, 16'h0014, 16'h03e8, 16'h0000};
  logic        mclk, rst, hsel, hwrite, fitted, hrdy, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] volt, load;
  bsr_stage_s  stage;
  bsr_status_s st;
  int          n_fail = 0;
  int          n_checks = 0;
  int          n;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  bsr_shunt_ctrl #(.TICK_CYC(TICK)) i_bsr_shunt_ctrl (
    .mclk_i(mclk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .stage_i(stage), .status_o(st));

  bsr_stage_model i_bsr_stage_model (.brake_on_i(st.brake_on), .fitted_i(fitted),
    .volt_i(volt), .load_pwr_i(load), .stage_o(stage));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk_rng(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : chk_rng

  // Bounded wait for the slave's ready; a stuck bus ends the run
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (hrdy === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_rdy

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd_chk

  // Status is looked at on the falling edge, clear of register updates
  task automatic wait_bit(input int b, input logic v, input int nt);
    int i;
    for (i = 0; i < nt * TICK; i++) begin
      @(negedge mclk);
      if (st[b] === v) break;
    end
    chk({31'h0, st[b]}, {31'h0, v});
    if (i == nt * TICK) print_verdict();
  endtask : wait_bit

  task automatic span(input logic v, output int c);
    c = 0;
    while (st.brake_on === v && c < 2000) begin
      @(negedge mclk);
      c++;
    end
    if (c == 2000) begin
      n_fail++;
      print_verdict();
    end
  endtask : span

  initial begin
    {rst, fitted} = 2'b11;
    {hsel, hwrite, htrans, haddr, hwdata, volt, load} = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++) rd_chk(RA[i], {16'h0, RV[i]});
    wr(`BSR_OFS_MODE, 32'h5);
    rd_chk(`BSR_OFS_MODE, 32'h1);
    // Off: high bus voltage must not switch
    wr(`BSR_OFS_MODE, 32'h0);
    volt <= 16'd800;
    repeat (5 * TICK) @(negedge mclk);
    chk({31'h0, st.brake_on}, 32'h0);
    // Threshold only, low-voltage levels
    @(posedge mclk);
    volt <= 16'd370;
    wr(`BSR_OFS_ON_VOLT, 32'd390);
    wr(`BSR_OFS_OFF_VOLT, 32'd380);
    wr(`BSR_OFS_MODE, 32'h3);
    volt <= 16'd395;
    wait_bit(BRK, 1'b1, 3);
    @(posedge mclk);
    volt <= 16'd385;
    repeat (8 * TICK) @(negedge mclk);
    chk({31'h0, st.brake_on}, 32'h1);
    @(posedge mclk);
    volt <= 16'd375;
    wait_bit(BRK, 1'b0, 3);
    // Warning only: overload warns but never faults
    wr(`BSR_OFS_MODE, 32'h4);
    volt <= 16'd395;
    load <= 16'd1200;
    wait_bit(WRN, 1'b1, 100);
    chk({24'h0, st.display_code}, {24'h0, `BSR_CODE_WARN});
    repeat (300 * TICK) @(negedge mclk);
    chk({30'h0, st.power_fault, st.brake_on}, 32'h1);
    begin
      logic [31:0] q;
      bus(1'b0, `BSR_OFS_PWR_FILT, 32'h0, q);
      chk_rng(int'(q), 1199, 1200);
    end
    // Fault only: same overload now trips and latches
    wr(`BSR_OFS_MODE, 32'h3);
    wait_bit(PF, 1'b1, 3);
    repeat (2) @(negedge mclk);
    chk({22'h0, st.brake_on, st.drive_disable, st.display_code}, 32'h0103);
    @(posedge mclk);
    volt <= 16'd0;
    repeat (10 * TICK) @(negedge mclk);
    chk({31'h0, st.power_fault}, 32'h1);
    wr(`BSR_OFS_CTRL, 32'h2);
    wait_bit(PF, 1'b0, 1);
    // Duty limited at the high-voltage levels
    @(posedge mclk);
    load <= 16'd0;
    wr(`BSR_OFS_ON_VOLT, 32'd780);
    wr(`BSR_OFS_OFF_VOLT, 32'd760);
    wr(`BSR_OFS_MODE, 32'h1);
    volt <= 16'd800;
    wait_bit(BRK, 1'b1, 3);
    span(1'b1, n);
    chk_rng(n, 4 * TICK, 6 * TICK);
    span(1'b0, n);
    chk_rng(n, 4 * TICK, 7 * TICK);
    span(1'b1, n);
    chk_rng(n, TICK / 2, 2 * TICK);
    @(posedge mclk);
    volt <= 16'd700;
    repeat (40 * TICK) @(negedge mclk);
    @(posedge mclk);
    volt <= 16'd800;
    wait_bit(BRK, 1'b1, 3);
    span(1'b1, n);
    chk_rng(n, 4 * TICK, 6 * TICK);
    // Mode 2 still limits the duty cycle
    wr(`BSR_OFS_MODE, 32'h2);
    wait_bit(BRK, 1'b1, 8);
    span(1'b1, n);
    chk_rng(n, TICK / 2, 2 * TICK);
    // Resistance too low for the transistor current
    wr(`BSR_OFS_INT_RES, 32'd30);
    wait_bit(CFG, 1'b1, 1);
    repeat (3 * TICK) @(negedge mclk);
    chk({23'h0, st.brake_on, st.display_code}, {24'h0, `BSR_CODE_CFG});
    wr(`BSR_OFS_INT_RES, 32'd100);
    wait_bit(CFG, 1'b0, 1);
    // External only: refused until data saved
    @(posedge mclk);
    volt <= 16'd0;
    fitted <= 1'b0;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    wait_bit(CFG, 1'b1, 1);
    rd_chk(`BSR_OFS_EXT_RES, 32'h0);
    wr(`BSR_OFS_EXT_RES, 32'd100);
    wr(`BSR_OFS_EXT_PWR, 32'd1000);
    repeat (3 * TICK) @(negedge mclk);
    chk({31'h0, st.config_fault}, 32'h1);
    wr(`BSR_OFS_CTRL, 32'h1);
    wait_bit(CFG, 1'b0, 1);
    rd_chk(`BSR_OFS_CTRL, 32'h1);
    print_verdict();
  end
endmodule : tb_top
